// [core/bst_port.sv]
// Purpose: boundary scan test port with AHB-Lite control
// Assumes: tck well below hclk/4; pins asynchronous
// Notes:   hclk samples tck and finds its edges
`timescale 1ns/1ns
`include "bst_defs.svh"
module bst_port import bst_pkg::*; #(
  parameter int NUM_IOB = 4
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire bst_pins_s         scan_pin_i,
  output logic                   tdo_pin_o,
  output logic                   tdo_pin_oe,
  input  wire logic              user_tdo_o,
  input  wire logic              user_tdo_oe,
  output bst_pins_s              user_pin_o,
  input  wire logic [NUM_IOB:0]  pad_i,
  output logic      [NUM_IOB:0]  pad_o,
  output logic      [NUM_IOB:0]  pad_oe,
  input  wire logic [NUM_IOB:0]  core_o,
  input  wire logic [NUM_IOB:0]  core_oe,
  output logic      [NUM_IOB:0]  core_i,
  input  wire logic              mode_select_bit0,
  input  wire logic              mode_select_bit2,
  output logic      [1:0]        mode_in_core,
  input  wire logic              int_tri_cap,
  input  wire logic              int_out_cap,
  output logic                   internal_update_cell
);

  // pad index NUM_IOB is the mode_select_bit1 output pin
  localparam int NIO   = NUM_IOB + 1;
  localparam int BSR_W = 5 + 3 * NIO;
  localparam int SW    = 3 + NIO + 2;
  localparam int IRW   = `BST_IR_W;
  localparam int CFW   = `BST_CFG_W;

  // all assertions below run on hclk and pause in reset
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // elaboration check: at least one io block
  if (NUM_IOB < 1) begin : g_bad_iob
    $error("bst_port: NUM_IOB must be at least 1");
  end

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  // controller step on a rising tck edge
  function automatic bst_tap_e tap_next(input bst_tap_e s, input logic m);
    case (s)
      TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_IDLE;
      TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_TLR;
    endcase
  endfunction : tap_next

  // boundary register serves both sample/preload and extest
  function automatic logic is_bsr(input logic [IRW-1:0] ir);
    is_bsr = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE);
  endfunction : is_bsr

  // configure-in and read-back share one data register
  function automatic logic is_cfg(input logic [IRW-1:0] ir);
    is_cfg = (ir == `BST_IR_CFGIN) || (ir == `BST_IR_RDBACK);
  endfunction : is_cfg

  // -----------------------------------------------------------------
  // pin synchronisation and tck edges
  // -----------------------------------------------------------------
  bst_pins_s    pin_s;
  logic [NIO-1:0] pad_s;
  logic [1:0]   mode_s;
  logic         tck_p_q;
  wire          tck_rise = pin_s.tck & ~tck_p_q;
  wire          tck_fall = ~pin_s.tck & tck_p_q;

  bst_sync #(.W(SW)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({scan_pin_i, pad_i, mode_select_bit2, mode_select_bit0}),
    .dout    ({pin_s, pad_s, mode_s})
  );

  // inputs pass on to core logic after synchronising
  assign core_i       = pad_s;
  assign mode_in_core = mode_s;

  // -----------------------------------------------------------------
  // register bus
  // -----------------------------------------------------------------
  logic [2:0]     ctrl_q;
  logic [CFW-1:0] rdback_q;
  logic [CFW-1:0] cfg_word_q;
  logic           cfg_new_q;
  logic           wr_pend_q;
  logic [9:0]     wr_idx_q;
  logic [31:0]    rd_val;
  bst_tap_e       state_q;
  logic [IRW-1:0] ir_q;

  wire       addr_ok = hsel & htrans[1] & hready;
  wire [9:0] a_idx   = haddr[11:2];
  wire       wr_ctrl = wr_pend_q & (wr_idx_q == `BST_OFS_CTRL);
  wire       wr_stat = wr_pend_q & (wr_idx_q == `BST_OFS_STATUS);
  wire       wr_rdbk = wr_pend_q & (wr_idx_q == `BST_OFS_RDBACK);

  // scan stays on after configuration only with the keep symbol
  wire scan_active = ctrl_q[`BST_CTRL_SCAN] &
                     (~ctrl_q[`BST_CTRL_DONE] |
                      ctrl_q[`BST_CTRL_KEEP]);

  // read mux; unmapped offsets read zero
  assign rd_val =
    (a_idx == `BST_OFS_CTRL)   ? {29'h0, ctrl_q} :
    (a_idx == `BST_OFS_STATUS) ? {23'h0, cfg_new_q, scan_active,
                                  ir_q, state_q} :
    (a_idx == `BST_OFS_CFGIN)  ? cfg_word_q :
    (a_idx == `BST_OFS_RDBACK) ? rdback_q : 32'h0000_0000;

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture, read data loaded for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 10'h000;
      hrdata    <= `BST_WORD_RST;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_idx_q  <= a_idx;
      if (addr_ok & ~hwrite) hrdata <= rd_val;
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= `BST_CTRL_RST;
      rdback_q <= `BST_WORD_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[2:0];
      if (wr_rdbk) rdback_q <= hwdata;
    end
  end

  // -----------------------------------------------------------------
  // test access controller
  // -----------------------------------------------------------------
  // no test reset pin: hresetn is power-on only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= TAP_TLR;
      tck_p_q <= 1'b0;
    end else begin
      tck_p_q <= pin_s.tck;
      if (!scan_active) state_q <= TAP_TLR;
      else if (tck_rise)
        state_q <= tap_next(state_q, pin_s.tms);
    end
  end

  // pins keep feeding user logic even while scan owns them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) user_pin_o <= '0;
    else user_pin_o <= pin_s;
  end

  // -----------------------------------------------------------------
  // shift registers (rising tck)
  // -----------------------------------------------------------------
  logic [IRW-1:0]   ir_sr_q;
  logic             byp_q;
  logic [BSR_W-1:0] bsr_sr_q;
  logic [BSR_W-1:0] bsr_upd_q;
  logic [CFW-1:0]   cfg_sr_q;
  logic [BSR_W-1:0] bsr_cap;

  // capture image: internal cells first, update cell last
  assign bsr_cap[0] = int_tri_cap;
  assign bsr_cap[1] = int_out_cap;
  for (genvar k = 0; k < NIO; k++) begin : g_cap
    assign bsr_cap[2+3*k] = pad_s[k];
    assign bsr_cap[3+3*k] = core_o[k];
    assign bsr_cap[4+3*k] = core_oe[k];
  end
  assign bsr_cap[2+3*NIO] = mode_s[0];
  assign bsr_cap[3+3*NIO] = mode_s[1];
  assign bsr_cap[BSR_W-1] = bsr_upd_q[BSR_W-1];

  wire cap_dr = tck_rise & (state_q == TAP_CAP_DR);
  wire sh_dr  = tck_rise & (state_q == TAP_SH_DR);
  wire tdi    = pin_s.tdi;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_sr_q <= `BST_IR_BYPASS;
    end else if (tck_rise && state_q == TAP_CAP_IR) begin
      ir_sr_q <= `BST_IR_CAPTURE;
    end else if (tck_rise && state_q == TAP_SH_IR) begin
      ir_sr_q <= {tdi, ir_sr_q[IRW-1:1]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byp_q    <= 1'b0;
      bsr_sr_q <= '0;
      cfg_sr_q <= `BST_WORD_RST;
    end else begin
      if (cap_dr) byp_q <= 1'b0;
      else if (sh_dr) byp_q <= tdi;
      if (cap_dr && is_bsr(ir_q)) bsr_sr_q <= bsr_cap;
      else if (sh_dr && is_bsr(ir_q))
        bsr_sr_q <= {tdi, bsr_sr_q[BSR_W-1:1]};
      if (cap_dr && ir_q == `BST_IR_RDBACK)
        cfg_sr_q <= rdback_q;
      else if (sh_dr && is_cfg(ir_q))
        cfg_sr_q <= {tdi, cfg_sr_q[CFW-1:1]};
    end
  end

  // -----------------------------------------------------------------
  // update and tdo (falling tck)
  // -----------------------------------------------------------------
  wire upd_dr  = tck_fall & (state_q == TAP_UPD_DR);
  wire shifting = (state_q == TAP_SH_DR) | (state_q == TAP_SH_IR);
  wire dr_bit  = is_bsr(ir_q) ? bsr_sr_q[0] :
                 is_cfg(ir_q) ? cfg_sr_q[0] : byp_q;
  logic tdo_q;
  logic tdo_en_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_q      <= `BST_IR_BYPASS;
      bsr_upd_q <= '0;
      tdo_q     <= 1'b0;
      tdo_en_q  <= 1'b0;
    end else begin
      if (state_q == TAP_TLR) ir_q <= `BST_IR_BYPASS;
      else if (tck_fall && state_q == TAP_UPD_IR) ir_q <= ir_sr_q;
      if (upd_dr && is_bsr(ir_q)) bsr_upd_q <= bsr_sr_q;
      if (!scan_active) tdo_en_q <= 1'b0;
      else if (tck_fall) begin
        tdo_en_q <= shifting;
        tdo_q    <= (state_q == TAP_SH_IR) ? ir_sr_q[0] : dr_bit;
      end
    end
  end

  // received configuration word; set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_word_q <= `BST_WORD_RST;
      cfg_new_q  <= 1'b0;
    end else if (upd_dr && ir_q == `BST_IR_CFGIN) begin
      cfg_word_q <= cfg_sr_q;
      cfg_new_q  <= 1'b1;
    end else if (wr_stat && hwdata[`BST_ST_NEW]) begin
      cfg_new_q  <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // pad drive
  // -----------------------------------------------------------------
  wire extest = scan_active & (ir_q == `BST_IR_EXTEST);

  // outputs registered so extest switches glitch-free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_o  <= '0;
      pad_oe <= '0;
    end else begin
      for (int k = 0; k < NIO; k++) begin
        pad_o[k]  <= extest ? bsr_upd_q[3+3*k] : core_o[k];
        pad_oe[k] <= extest ? bsr_upd_q[4+3*k] : core_oe[k];
      end
    end
  end

  assign internal_update_cell = bsr_upd_q[BSR_W-1];

  // tdo pin: scan driver or unregistered user output
  assign tdo_pin_o  = scan_active ? tdo_q : user_tdo_o;
  assign tdo_pin_oe = scan_active ? tdo_en_q : user_tdo_oe;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  logic [2:0] tms_run_q;

  // helper: run of tms-high rising edges, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tms_run_q <= 3'h0;
    else if (tck_rise)
      tms_run_q <= !pin_s.tms ? 3'h0 :
                   (tms_run_q == 3'h7) ? 3'h7 : tms_run_q + 3'h1;
  end

  property p_tms_reset;
    (tms_run_q >= `BST_TMS_RESET_RISES) |-> state_q == TAP_TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("tms run did not reach reset");
  property p_tdo_shift;
    $rose(tdo_en_q) |-> $past(tck_fall) && $past(shifting);
  endproperty
  a_tdo_shift: assert property (p_tdo_shift) else $error("tdo enabled outside a falling shift edge");
  property p_idle_reset;
    !scan_active |=> state_q == TAP_TLR && !tdo_en_q;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("controller active while scan disabled");
  property p_user_tdo;
    !scan_active |-> tdo_pin_o == user_tdo_o && tdo_pin_oe == user_tdo_oe;
  endproperty
  a_user_tdo: assert property (p_user_tdo) else $error("tdo pin not following user output");
  property p_keep;
    (ctrl_q == 3'h7) |-> scan_active;
  endproperty
  a_keep: assert property (p_keep) else $error("keep symbol did not hold scan enabled");
  property p_user_pins;
    ##1 user_pin_o == $past(pin_s);
  endproperty
  a_user_pins: assert property (p_user_pins) else $error("scan pins not passed to user logic");
  property p_bypass;
    sh_dr && ir_q == `BST_IR_BYPASS |=> byp_q == $past(pin_s.tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass cell missed tdi");
  // compare with the cell as it stood when the pad was loaded
  property p_extest;
    extest |=> pad_oe[0] == $past(bsr_upd_q[4]);
  endproperty
  a_extest: assert property (p_extest) else $error("extest enable not driven from cell");
  property p_cap_ir;
    tck_rise && state_q == TAP_CAP_IR |=> ir_sr_q == `BST_IR_CAPTURE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("instruction capture pattern wrong");
  property p_cfg_new;
    upd_dr && ir_q == `BST_IR_CFGIN |=> cfg_new_q && cfg_word_q == $past(cfg_sr_q);
  endproperty
  a_cfg_new: assert property (p_cfg_new) else $error("configure word not taken");

  // main scenarios reached
  c_tms_reset: cover property ($past(state_q) != TAP_TLR && state_q == TAP_TLR && scan_active);
  c_extest: cover property (extest && pad_oe != '0);
  c_cfg_in: cover property ($rose(cfg_new_q));
  c_rdback: cover property (sh_dr && ir_q == `BST_IR_RDBACK);

endmodule : bst_port

// [core/bst_defs.svh]
// Purpose: constants of the boundary scan test port
// Assumes: 32-bit AHB-Lite register bus, 100 MHz hclk
// Notes:   offsets, field positions, resets, encodings
//
// Summary of operation
// - bypass, sample/preload and extest instructions supported
// - scan option claims tdi, tms, tck pins
// - scan option claims one output as tdo
// - no test reset pin; tms resets
// - sixteen-state controller, instruction and data registers
// - extra instructions: configure in, read back
// - per io block: in, out, 3-state cells
// - mode bits 0 and 2: in cell only
// - mode bit 1 output: all three cells
// - first cells capture internal 3-state, output
// - last cell is update cell driving net
// - without keep symbol, scan only during configuration
// - keep symbol keeps scan enabled after configuration
// - tms, tck, tdi still reach user logic
// - scan unused: tdo pin is plain 3-state output
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// -----------------------------------------------------------------
// register word index (byte address is four times)
// -----------------------------------------------------------------
`define BST_OFS_CTRL     10'h000
`define BST_OFS_STATUS   10'h001
`define BST_OFS_CFGIN    10'h002
`define BST_OFS_RDBACK   10'h003

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define BST_CTRL_SCAN    0
`define BST_CTRL_KEEP    1
`define BST_CTRL_DONE    2
`define BST_ST_IR_LO     4
`define BST_ST_ACTIVE    7
`define BST_ST_NEW       8
`define BST_CTRL_RST     3'h0
`define BST_WORD_RST     32'h0000_0000

// -----------------------------------------------------------------
// instruction register
// -----------------------------------------------------------------
`define BST_IR_W         3
`define BST_IR_EXTEST    3'h0
`define BST_IR_SAMPLE    3'h1
`define BST_IR_RDBACK    3'h4
`define BST_IR_CFGIN     3'h5
`define BST_IR_BYPASS    3'h7
`define BST_IR_CAPTURE   3'h1
`define BST_CFG_W        32

// -----------------------------------------------------------------
// timing: rising tck edges of tms high that reach reset
// -----------------------------------------------------------------
`define BST_TMS_RESET_RISES 3'h5

`endif

// [core/bst_pkg.sv]
// Purpose: types of the boundary scan test port
// Assumes: bst_defs.svh for all numbers
// Notes:   state enum carries no codes
package bst_pkg;

  // -----------------------------------------------------------------
  // test access controller states
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_TLR, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR,
    TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } bst_tap_e;

  // synchronised scan pins as one bundle
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_s;

endpackage : bst_pkg

// [core/bst_sync.sv]
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are levels, not pulses
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module bst_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // -----------------------------------------------------------------
  // two stages, constant reset
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

  // elaboration check: zero width cannot be synchronised
  if (W < 1) begin : g_bad_w
    $error("bst_sync: width must be at least 1");
  end

endmodule : bst_sync

// [dv/bst_tester.sv]
// Purpose: board tester model driving the scan pins
// Assumes: tck period 125 ns, tck parked low between frames
// Notes:   tdo read just before each tck rise
`timescale 1ns/1ns
module bst_tester import bst_pkg::*; (
  output bst_pins_s  pins,
  input  wire logic  tdo,
  input  wire logic  tdo_oe
);
  initial pins = '0;

  // -----------------------------------------------------------------
  // one tck period: tms/tdi change only while tck is low
  // -----------------------------------------------------------------
  task automatic step(input logic tms, input logic tdi, output logic q);
    pins.tms = tms;
    pins.tdi = tdi;
    #62;
    q = tdo_oe ? tdo : 1'bx;
    pins.tck = 1'b1;
    #63;
    pins.tck = 1'b0;
    // no stale level on tdi once the bit is taken
    pins.tdi = ~tdi;
  endtask : step
endmodule : bst_tester

// [dv/tb_top.sv]
// Purpose: self-checking bench of the boundary scan port
// Assumes: hclk 100 MHz, tester tck 125 ns unrelated in phase
// Notes:   NUM_IOB reduced to 2, chain length follows from it
`timescale 1ns/1ns
module tb_top import bst_pkg::*;;
  localparam int N = 2;
  localparam int L = 5 + 3 * (N + 1);
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, d, rs = 32'd88285;
  logic [1:0]  htrans = 0, mic;
  logic        hreadyout, hresp, tdo_o, tdo_oe, utdo = 0, utdoe = 0, upd_cell, upd_exp = 0;
  bst_pins_s   pins, upin;
  logic [N:0]  pad = 0, po, poe, co = 0, coe = 0, ci, eo, eoe;
  logic        m0 = 0, m2 = 0, it = 0, io = 0;
  int          num_errors = 0, checked = 0, cyc = 0;

  always #5 hclk = ~hclk;

  bst_port #(.NUM_IOB(N)) bst_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scan_pin_i(pins), .tdo_pin_o(tdo_o), .tdo_pin_oe(tdo_oe),
    .user_tdo_o(utdo), .user_tdo_oe(utdoe), .user_pin_o(upin), .pad_i(pad), .pad_o(po), .pad_oe(poe),
    .core_o(co), .core_oe(coe), .core_i(ci), .mode_select_bit0(m0), .mode_select_bit2(m2),
    .mode_in_core(mic), .int_tri_cap(it), .int_out_cap(io), .internal_update_cell(upd_cell));
  bst_tester bst_tester_i (.pins(pins), .tdo(tdo_o), .tdo_oe(tdo_oe));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd

  // boundary chain as captured, bit 0 leaves first
  function automatic logic [31:0] chain(input logic u);
    logic [31:0] c;
    c = '0;
    c[0] = it;
    c[1] = io;
    for (int k = 0; k <= N; k++) begin
      c[2+3*k] = pad[k];
      c[3+3*k] = co[k];
      c[4+3*k] = coe[k];
    end
    c[L-3] = m0;
    c[L-2] = m2;
    c[L-1] = u;
    return c;
  endfunction : chain

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // single AHB-Lite word transfer, waits on hready each phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({hreadyout, hresp}, 32'h2);
  endtask : bus

  // from idle: one ir or dr scan of n bits, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    bst_tester_i.step(1'b1, 1'b0, b);
    if (ir) bst_tester_i.step(1'b1, 1'b0, b);
    bst_tester_i.step(1'b0, 1'b0, b);
    bst_tester_i.step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      bst_tester_i.step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    bst_tester_i.step(1'b1, 1'b0, b);
    bst_tester_i.step(1'b0, 1'b0, b);
  endtask : scan

  task automatic ld(input logic [31:0] code);
    logic [31:0] r;
    scan(1'b1, 3, code, r);
    chk(r, 32'h1);
    chk(tdo_oe, 1'b0);
  endtask : ld

  task automatic user_tdo();
    d = rnd();
    @(posedge hclk);
    utdo <= d[0];
    utdoe <= d[1];
    repeat (2) @(posedge hclk);
    chk({tdo_oe, tdo_o}, d[1:0]);
  endtask : user_tdo

  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    logic b;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0, 0, q);
    chk(q, 32'h0);
    bus(1'b0, 32'h4, 0, q);
    chk(q, 32'h70);
    bus(1'b1, 32'h10, 32'hFFFF_FFFF, q);
    bus(1'b0, 32'h10, 0, q);
    chk(q, 32'h0);
    repeat (3) user_tdo();
    bus(1'b1, 32'h0, 32'h1, q);
    bus(1'b0, 32'h4, 0, q);
    chk(q[7], 1'b1);
    // random walks, then five tms-high rises
    for (int r = 0; r < 4; r++) begin
      d = rnd();
      for (int j = 0; j < d[2:0] + 2; j++) bst_tester_i.step(d[j+3], d[j+12], b);
      repeat (5) bst_tester_i.step(1'b1, d[r+20], b);
      bus(1'b0, 32'h4, 0, q);
      chk(q[3:0], 4'h0);
    end
    // shared pins: tms kept high, tdi toggled
    for (int r = 0; r < 3; r++) begin
      d = rnd();
      bst_tester_i.step(1'b1, d[0], b);
      repeat (5) @(posedge hclk);
      chk(upin, pins);
    end
    bst_tester_i.step(1'b0, 1'b0, b);
    @(posedge hclk);
    d = rnd();
    pad <= d[2:0];
    co <= d[5:3];
    coe <= d[8:6];
    {m0, m2, it, io} <= d[12:9];
    repeat (6) @(posedge hclk);
    chk({poe, po, ci, mic}, {coe, co, pad, m2, m0});
    // sample then extest with the preloaded cells
    ld(32'h1);
    bus(1'b0, 32'h4, 0, q);
    chk(q[6:0], 7'h11);
    d = rnd();
    scan(1'b0, L, d, q);
    chk(q & ((1 << L) - 1), chain(upd_exp));
    chk(upd_cell, d[L-1]);
    chk(po, co);
    for (int k = 0; k <= N; k++) begin
      eo[k] = d[3+3*k];
      eoe[k] = d[4+3*k];
    end
    ld(32'h0);
    repeat (4) @(posedge hclk);
    chk({poe, po}, {eoe, eo});
    // unused codes behave as bypass
    for (int i = 2; i < 8; i++) if (i != 4 && i != 5) begin
      ld(i);
      q = rnd();
      scan(1'b0, 8, q, d);
      chk(d[7:0], {q[6:0], 1'b0});
      d = q;
    end
    chk(po, co);
    ld(32'h5);
    d = rnd();
    scan(1'b0, 32, d, q);
    bus(1'b0, 32'h8, 0, q);
    chk(q, d);
    bus(1'b0, 32'h4, 0, q);
    chk(q[8], 1'b1);
    bus(1'b1, 32'h4, 32'h100, q);
    bus(1'b0, 32'h4, 0, q);
    chk(q[8], 1'b0);
    d = rnd();
    bus(1'b1, 32'hC, d, q);
    ld(32'h4);
    scan(1'b0, 32, 0, q);
    chk(q, d);
    // configuration done, with and without keep
    bus(1'b1, 32'h0, 32'h5, q);
    bus(1'b0, 32'h4, 0, q);
    chk(q[7], 1'b0);
    user_tdo();
    bus(1'b1, 32'h0, 32'h7, q);
    bus(1'b0, 32'h4, 0, q);
    chk(q[7:0], 8'hF0);
    complete_run();
  end
endmodule : tb_top
